// *** logic/dbtu_pkg.sv ***
package dbtu_pkg;

    localparam int DBTU_DATA_W = 32;
    localparam int DBTU_SEL_W = 4;
    localparam int DBTU_REG_COUNT = 11;

    // Register select codes carried by both write paths
    localparam logic [3:0] DBTU_SEL_PC_BASE = 4'h0;
    localparam logic [3:0] DBTU_SEL_PC_ENTRY1 = 4'h1;
    localparam logic [3:0] DBTU_SEL_PC_ENTRY2 = 4'h2;
    localparam logic [3:0] DBTU_SEL_PC_ENTRY3 = 4'h3;
    localparam logic [3:0] DBTU_SEL_PC_MASK = 4'h4;
    localparam logic [3:0] DBTU_SEL_ADDR_LOW = 4'h5;
    localparam logic [3:0] DBTU_SEL_ADDR_HIGH = 4'h6;
    localparam logic [3:0] DBTU_SEL_DATA_VALUE = 4'h7;
    localparam logic [3:0] DBTU_SEL_DATA_MASK = 4'h8;
    localparam logic [3:0] DBTU_SEL_TRIG_DEF = 4'h9;
    localparam logic [3:0] DBTU_SEL_TRACE_CTRL = 4'hA;

    localparam logic [31:0] DBTU_REG_RESET = 32'h0000_0000;

    // Trigger definition fields
    localparam int DBTU_TD_PC_INV = 0;
    localparam int DBTU_TD_PC_EN = 1;
    localparam int DBTU_TD_ADDR_LOW = 2;
    localparam int DBTU_TD_ADDR_RANGE = 3;
    localparam int DBTU_TD_ADDR_OUT = 4;
    localparam int DBTU_TD_DATA_INV = 5;
    localparam int DBTU_TD_DATA_QUAL = 6;
    localparam int DBTU_TD_MODE_LSB = 7;
    localparam int DBTU_TD_MODE_W = 3;

    // Trace control fields
    localparam int DBTU_TC_START_LSB = 0;
    localparam int DBTU_TC_STOP_LSB = 2;
    localparam int DBTU_TC_SRC_W = 2;
    localparam logic [1:0] DBTU_SRC_NONE = 2'h0;
    localparam logic [1:0] DBTU_SRC_PC = 2'h1;
    localparam logic [1:0] DBTU_SRC_ADDR = 2'h2;
    localparam logic [1:0] DBTU_SRC_ADDR_DATA = 2'h3;

    localparam int DBTU_VALID_BIT = 0;

    localparam logic [2:0] DBTU_MODE_OFF = 3'h0;
    localparam logic [2:0] DBTU_MODE_PC = 3'h1;
    localparam logic [2:0] DBTU_MODE_PC_OR_ADDR = 3'h2;
    localparam logic [2:0] DBTU_MODE_ADDR = 3'h3;
    localparam logic [2:0] DBTU_MODE_PC_THEN_ADDR = 3'h4;
    localparam logic [2:0] DBTU_MODE_ADDR_THEN_PC = 3'h5;

    typedef enum logic [1:0] {
        DBTU_SIZE_BYTE = 2'h0,
        DBTU_SIZE_WORD = 2'h1,
        DBTU_SIZE_LONG = 2'h2
    } dbtu_size_t;

    typedef struct packed {
        logic valid;
        logic [3:0] sel;
        logic [31:0] data;
    } dbtu_wr_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        dbtu_size_t size;
        logic [31:0] data;
    } dbtu_xfer_t;

endpackage

// *** logic/dbtu_top.sv ***
`timescale 1ns/1ps
// Operation
// R1 - Mask bits drop base-entry PC bits
// R2 - Mask applies only to base entry
// R3 - Bit 0 enables each unmasked entry
// R4 - Unmasked entries compare PC bits 31-1
// R5 - Software keeps base entry bit 0 zero
// R6 - Software sets top address byte correctly
// R7 - Address compared on every local-bus transfer
// R8 - Address match: exact, inside, or outside
// R9 - Data mask bits drop data compare bits
// R10 - Operand lane from address and size
// R11 - Three one-level trigger forms supported
// R12 - Two two-level arm-then-fire sequences
// R13 - PC match ORs all four entries
// R14 - Data match only qualifies address match
// R15 - Writable by instruction and background port
// R16 - Comparators also start and stop trace
// R17 - Data invert bit flips data match
// R18 - Bits 4-2 pick address match type
// R19 - PC enable bit 1, invert bit 0
// R20 - Armed flag cleared by reset, redefinition
module dbtu_top
    import dbtu_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dbtu_wr_t instr_wr_in,
    input wire dbtu_wr_t port_wr_in,
    input wire logic pc_valid_in,
    input wire logic [31:0] pc_in,
    input wire dbtu_xfer_t xfer_in,
    output logic pc_match_out,
    output logic addr_match_out,
    output logic data_match_out,
    output logic armed_out,
    output logic trigger_out,
    output logic trace_start_out,
    output logic trace_stop_out
);

    logic rst_meta_n_q;
    logic rst_sync_n_q;
    logic [31:0] regs_q [DBTU_REG_COUNT];
    dbtu_wr_t wr;
    logic trig_def_wr;
    logic [31:0] td;
    logic [31:0] tc;
    logic [2:0] mode;
    logic [3:0] pc_hit;
    logic pc_any;
    logic pc_m;
    logic addr_low_hit;
    logic addr_in_range;
    logic addr_m;
    logic [31:0] lane_mask;
    logic data_eq;
    logic data_m;
    logic addr_term;
    logic first_ev;
    logic second_ev;
    logic two_level;
    logic fire_d;
    logic armed_q;

    // Intermediate terms kept apart so each compare stays readable
    logic [DBTU_REG_COUNT-1:0] wr_hit;
    logic [31:0] pc_base_diff;
    logic addr_above_low;
    logic addr_below_high;
    logic [3:0] lane_en;
    logic [31:0] data_diff;
    logic arm_set;
    logic arm_clr;
    logic trace_start_d;
    logic trace_stop_d;

    // Logic leaves reset on the second edge after release, never mid-cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_n_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_n_q <= 1'b1;
            rst_sync_n_q <= rst_meta_n_q;
        end
    end

    // Background port wins a same-cycle collision with the instruction
    always_comb begin
        if (port_wr_in.valid) begin
            wr = port_wr_in; // [R15]
        end else begin
            wr = instr_wr_in; // [R15]
        end
    end

    // A redefinition both drops the arm and blocks a fire in its cycle
    assign trig_def_wr = wr.valid && (wr.sel == DBTU_SEL_TRIG_DEF);

    genvar gi;
    generate
        for (gi = 0; gi < DBTU_REG_COUNT; gi++) begin : g_reg
            // Select codes above the last register decode to no entry
            assign wr_hit[gi] = wr.valid && (wr.sel == 4'(gi));

            always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
                if (!rst_sync_n_q) begin
                    regs_q[gi] <= DBTU_REG_RESET;
                end else if (wr_hit[gi]) begin
                    regs_q[gi] <= wr.data; // [R15]
                end
            end
        end
    endgenerate

    assign td = regs_q[DBTU_SEL_TRIG_DEF];
    assign tc = regs_q[DBTU_SEL_TRACE_CTRL];
    assign mode = td[DBTU_TD_MODE_LSB +: DBTU_TD_MODE_W];

    // Base entry with bit mask, other entries compare bits 31-1 with valid bit 0
    assign pc_base_diff = (pc_in ^ regs_q[DBTU_SEL_PC_BASE]) & ~regs_q[DBTU_SEL_PC_MASK]; // [R1]
    assign pc_hit[0] = pc_base_diff == 32'h0000_0000; // [R2]
    generate
        for (gi = 1; gi < 4; gi++) begin : g_pc
            logic entry_on;
            logic addr_eq;

            // Bit 0 is the valid flag, so it never joins the address compare
            assign entry_on = regs_q[gi][DBTU_VALID_BIT]; // [R3]
            assign addr_eq = pc_in[31:1] == regs_q[gi][31:1]; // [R4] [R2]
            assign pc_hit[gi] = entry_on && addr_eq;
        end
    endgenerate

    // Invert applies to the OR of all entries, not to each entry
    always_comb begin
        pc_any = |pc_hit; // [R13]
        pc_m = pc_valid_in && td[DBTU_TD_PC_EN] && (pc_any ^ td[DBTU_TD_PC_INV]); // [R19]
    end

    // Both bounds count as inside; compare is unsigned over all 32 bits
    always_comb begin
        addr_low_hit = xfer_in.addr == regs_q[DBTU_SEL_ADDR_LOW];
        addr_above_low = xfer_in.addr >= regs_q[DBTU_SEL_ADDR_LOW];
        addr_below_high = xfer_in.addr <= regs_q[DBTU_SEL_ADDR_HIGH];
    end

    // A low bound above the high bound leaves the range empty
    assign addr_in_range = addr_above_low && addr_below_high;

    always_comb begin
        addr_m = xfer_in.valid && ( // [R7]
            (td[DBTU_TD_ADDR_LOW] && addr_low_hit)
            || (td[DBTU_TD_ADDR_RANGE] && addr_in_range)
            || (td[DBTU_TD_ADDR_OUT] && !addr_in_range)); // [R8] [R18]
    end

    // Lane enables follow the big-endian byte order of the bus
    always_comb begin
        lane_en = 4'hF;
        case (xfer_in.size)
            DBTU_SIZE_BYTE: begin
                case (xfer_in.addr[1:0])
                    2'h0: lane_en = 4'h8;
                    2'h1: lane_en = 4'h4;
                    2'h2: lane_en = 4'h2;
                    default: lane_en = 4'h1;
                endcase
            end
            DBTU_SIZE_WORD: begin
                lane_en = xfer_in.addr[1] ? 4'h3 : 4'hC;
            end
            default: begin
                lane_en = 4'hF;
            end
        endcase // [R10]
    end

    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{lane_en[gi]}}; // [R10]
        end
    endgenerate

    // Unselected lanes carry stale bus bytes, so they are masked out
    assign data_diff = (xfer_in.data ^ regs_q[DBTU_SEL_DATA_VALUE])
        & ~regs_q[DBTU_SEL_DATA_MASK] & lane_mask; // [R9] [R10]
    assign data_eq = data_diff == 32'h0000_0000;

    // Data hit is only defined while a transfer is on the bus
    always_comb begin
        data_m = xfer_in.valid && (data_eq ^ td[DBTU_TD_DATA_INV]); // [R17]
    end

    // Data never fires alone; it only narrows an address hit
    assign addr_term = addr_m && (!td[DBTU_TD_DATA_QUAL] || data_m); // [R14]

    always_comb begin
        first_ev = 1'b0;
        second_ev = 1'b0;
        two_level = 1'b0;
        case (mode)
            DBTU_MODE_OFF: begin
                first_ev = 1'b0;
            end
            DBTU_MODE_PC: begin
                first_ev = pc_m; // [R11]
            end
            DBTU_MODE_PC_OR_ADDR: begin
                first_ev = pc_m || addr_term; // [R11]
            end
            DBTU_MODE_ADDR: begin
                first_ev = addr_term; // [R11]
            end
            DBTU_MODE_PC_THEN_ADDR: begin
                two_level = 1'b1;
                first_ev = pc_m;
                second_ev = addr_term; // [R12]
            end
            DBTU_MODE_ADDR_THEN_PC: begin
                two_level = 1'b1;
                first_ev = addr_term;
                second_ev = pc_m; // [R12]
            end
            default: begin
                first_ev = 1'b0;
            end
        endcase
    end

    // Only the second level may fire while armed
    assign fire_d = !trig_def_wr
        && (two_level ? (armed_q && second_ev) : first_ev); // [R12] [R20]

    // Same-cycle first and second events do not fire; arming needs a prior cycle
    assign arm_set = two_level && !armed_q && first_ev;
    assign arm_clr = trig_def_wr || fire_d;

    // Clearing has priority so a redefinition never leaves a stale arm
    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            armed_q <= 1'b0;
        end else if (arm_clr) begin
            armed_q <= 1'b0; // [R20]
        end else if (arm_set) begin
            armed_q <= 1'b1; // [R20]
        end
    end

    // Trace taps use the raw comparator terms, not the trigger sequencer
    always_comb begin
        case (tc[DBTU_TC_START_LSB +: DBTU_TC_SRC_W])
            DBTU_SRC_PC: begin
                trace_start_d = pc_m; // [R16]
            end
            DBTU_SRC_ADDR: begin
                trace_start_d = addr_m; // [R16]
            end
            DBTU_SRC_ADDR_DATA: begin
                trace_start_d = addr_term; // [R16]
            end
            default: begin
                trace_start_d = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (tc[DBTU_TC_STOP_LSB +: DBTU_TC_SRC_W])
            DBTU_SRC_PC: begin
                trace_stop_d = pc_m; // [R16]
            end
            DBTU_SRC_ADDR: begin
                trace_stop_d = addr_m; // [R16]
            end
            DBTU_SRC_ADDR_DATA: begin
                trace_stop_d = addr_term; // [R16]
            end
            default: begin
                trace_stop_d = 1'b0;
            end
        endcase
    end

    // One flop per output keeps each reset value and source in plain view
    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            pc_match_out <= 1'b0;
        end else begin
            pc_match_out <= pc_m; // [R19]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            addr_match_out <= 1'b0;
        end else begin
            addr_match_out <= addr_m; // [R8]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            data_match_out <= 1'b0;
        end else begin
            data_match_out <= data_m; // [R17]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            trigger_out <= 1'b0;
        end else begin
            trigger_out <= fire_d; // [R11]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            armed_out <= 1'b0;
        end else begin
            armed_out <= armed_q; // [R20]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            trace_start_out <= 1'b0;
        end else begin
            trace_start_out <= trace_start_d; // [R16]
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            trace_stop_out <= 1'b0;
        end else begin
            trace_stop_out <= trace_stop_d; // [R16]
        end
    end

endmodule

// *** testbench/dbtu_core_model.sv ***
`timescale 1ns/1ps
module dbtu_core_model
    import dbtu_pkg::*;
(
    input wire logic clk_in,
    output logic pc_valid_out,
    output logic [31:0] pc_out,
    output dbtu_xfer_t xfer_out
);
    initial begin
        pc_valid_out = 1'b0;
        pc_out = 32'h5555_5555;
        xfer_out = '{1'b0, 32'hAAAA_AAAA, DBTU_SIZE_LONG, 32'h5555_5555};
    end
    // Idle lines show inverted values so stale data cannot fake a match
    task automatic fetch(input logic [31:0] a);
        @(posedge clk_in);
        #1;
        pc_valid_out = 1'b1;
        pc_out = {a[31:1], 1'b0};
        @(posedge clk_in);
        #1;
        pc_valid_out = 1'b0;
        pc_out = ~pc_out;
    endtask
    task automatic access(input logic [31:0] a, input dbtu_size_t s, input logic [31:0] d);
        @(posedge clk_in);
        #1;
        xfer_out = '{1'b1, a, s, d};
        @(posedge clk_in);
        #1;
        xfer_out = '{1'b0, ~a, s, ~d};
    endtask
endmodule

// *** testbench/dbtu_top_assertions.sv ***
`timescale 1ns/1ps
module dbtu_checker
    import dbtu_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dbtu_wr_t instr_wr_in,
    input wire dbtu_wr_t port_wr_in,
    input wire logic pc_valid_in,
    input wire dbtu_xfer_t xfer_in,
    input wire logic pc_match_out,
    input wire logic addr_match_out,
    input wire logic data_match_out,
    input wire logic armed_out,
    input wire logic trigger_out,
    input wire logic trace_start_out,
    input wire logic trace_stop_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    dbtu_wr_t wr;
    logic def_seen_q;
    logic trc_seen_q;
    assign wr = port_wr_in.valid ? port_wr_in : instr_wr_in;
    // Nothing may fire before its control register was ever written
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            def_seen_q <= 1'b0;
            trc_seen_q <= 1'b0;
        end else if (wr.valid) begin
            def_seen_q <= def_seen_q | (wr.sel == DBTU_SEL_TRIG_DEF);
            trc_seen_q <= trc_seen_q | (wr.sel == DBTU_SEL_TRACE_CTRL);
        end
    end
    AST_ADDR_XFER: assert property (addr_match_out |-> $past(xfer_in.valid))
        else $error("address match without transfer");
    AST_DATA_XFER: assert property (data_match_out |-> $past(xfer_in.valid))
        else $error("data match without transfer");
    AST_PC_VALID: assert property (pc_match_out |-> $past(pc_valid_in))
        else $error("pc match without pc");
    AST_TRIG_SRC: assert property (trigger_out |-> pc_match_out || addr_match_out)
        else $error("trigger without pc or address match");
    AST_TRACE_SRC: assert property ((trace_start_out || trace_stop_out) |->
        pc_match_out || addr_match_out) else $error("trace event without match");
    AST_ARM_CLEAR: assert property (wr.valid && wr.sel == DBTU_SEL_TRIG_DEF |->
        ##2 !armed_out) else $error("armed kept over redefinition");
    AST_NO_DEF: assert property (!def_seen_q |-> !trigger_out && !armed_out)
        else $error("trigger before definition");
    AST_NO_TRACE: assert property (!trc_seen_q |-> !trace_start_out && !trace_stop_out)
        else $error("trace event before setup");
    AST_RST_QUIET: assert property ($rose(rst_n_in) |-> (!armed_out && !trigger_out) [*2])
        else $error("output active after reset");
    cover property (trigger_out && armed_out);
    cover property (trigger_out && data_match_out);
    cover property (trace_start_out);
endmodule
bind dbtu_top dbtu_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .instr_wr_in(instr_wr_in), .port_wr_in(port_wr_in), .pc_valid_in(pc_valid_in),
    .xfer_in(xfer_in), .pc_match_out(pc_match_out), .addr_match_out(addr_match_out),
    .data_match_out(data_match_out), .armed_out(armed_out), .trigger_out(trigger_out),
    .trace_start_out(trace_start_out), .trace_stop_out(trace_stop_out));

// *** testbench/debug_breakpoint_trigger_unit_tb.sv ***
`timescale 1ns/1ps
module debug_breakpoint_trigger_unit_tb;
    import dbtu_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dbtu_wr_t iw = '0;
    dbtu_wr_t pw = '0;
    logic pcv;
    logic [31:0] pc;
    dbtu_xfer_t xf;
    logic pm, am, dm, arm, trg, tst, tsp;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    dbtu_core_model core (.clk_in(clk), .pc_valid_out(pcv), .pc_out(pc), .xfer_out(xf));
    dbtu_top dut (.clk_in(clk), .rst_n_in(rst_n), .instr_wr_in(iw), .port_wr_in(pw),
        .pc_valid_in(pcv), .pc_in(pc), .xfer_in(xf), .pc_match_out(pm),
        .addr_match_out(am), .data_match_out(dm), .armed_out(arm), .trigger_out(trg),
        .trace_start_out(tst), .trace_stop_out(tsp));
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %b want %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [31:0] d, input logic p);
        if (p) pw = '{1'b1, s, d};
        else iw = '{1'b1, s, d};
        @(posedge clk);
        #1;
        pw.valid = 1'b0;
        iw.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic pcm(input logic [31:0] a, input logic e);
        core.fetch(a);
        chk(pm, e);
    endtask
    task automatic acc(input logic [31:0] a, input dbtu_size_t s, input logic [31:0] d);
        core.access(a, s, d);
    endtask
    task automatic dck(input logic [31:0] a, input dbtu_size_t s, input logic [31:0] d,
        input logic e);
        acc(a, s, d);
        chk(dm, e);
        chk(trg, e);
    endtask
    task automatic test_pc();
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_0082, 1'b0);
        wr(DBTU_SEL_PC_BASE, 32'h0000_1230, 1'b1);
        wr(DBTU_SEL_PC_MASK, 32'h0000_000F, 1'b0);
        pcm(32'h0000_123C, 1'b1);
        chk(trg, 1'b1);
        pcm(32'h0000_1240, 1'b0);
        wr(DBTU_SEL_PC_ENTRY2, 32'hFF00_4000, 1'b0);
        pcm(32'hFF00_4000, 1'b0);
        wr(DBTU_SEL_PC_ENTRY2, 32'hFF00_4001, 1'b1);
        pcm(32'hFF00_4000, 1'b1);
        pcm(32'hFF00_4004, 1'b0);
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_0083, 1'b0);
        pcm(32'hFF00_4000, 1'b0);
        pcm(32'h0000_2000, 1'b1);
        $display("test pc done");
    endtask
    task automatic test_addr();
        logic [31:0] ad [4] = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_0200, 32'h0000_0201};
        logic [3:0] ex [4] = '{4'b0000, 4'b0010, 4'b0110, 4'b1001};
        wr(DBTU_SEL_ADDR_LOW, 32'h0000_0100, 1'b1);
        wr(DBTU_SEL_ADDR_HIGH, 32'h0000_0200, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(DBTU_SEL_TRIG_DEF, 32'h0000_0180 | ((32'h2 << m) & 32'h1C), 1'b0);
            for (int i = 0; i < 4; i++) begin
                acc(ad[i], DBTU_SIZE_LONG, 32'h0000_0000);
                chk(am, ex[m][i]);
                chk(trg, ex[m][i]);
            end
        end
        $display("test addr done");
    endtask
    task automatic test_data();
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_01C8, 1'b0);
        wr(DBTU_SEL_ADDR_LOW, 32'h0000_0300, 1'b0);
        wr(DBTU_SEL_ADDR_HIGH, 32'h0000_03FF, 1'b0);
        wr(DBTU_SEL_DATA_VALUE, 32'h1122_3344, 1'b1);
        dck(32'h0000_0301, DBTU_SIZE_BYTE, 32'hAA22_BBCC, 1'b1);
        dck(32'h0000_0302, DBTU_SIZE_BYTE, 32'h0000_3400, 1'b0);
        dck(32'h0000_0303, DBTU_SIZE_BYTE, 32'h0000_0044, 1'b1);
        dck(32'h0000_0302, DBTU_SIZE_WORD, 32'hFFFF_3344, 1'b1);
        dck(32'h0000_0300, DBTU_SIZE_WORD, 32'h1122_0000, 1'b1);
        dck(32'h0000_0300, DBTU_SIZE_LONG, 32'h1122_3345, 1'b0);
        wr(DBTU_SEL_DATA_MASK, 32'h0000_000F, 1'b0);
        dck(32'h0000_0300, DBTU_SIZE_LONG, 32'h1122_3345, 1'b1);
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_01E8, 1'b0);
        dck(32'h0000_0300, DBTU_SIZE_LONG, 32'h1122_3344, 1'b0);
        dck(32'h0000_0300, DBTU_SIZE_LONG, 32'h5122_3344, 1'b1);
        $display("test data done");
    endtask
    task automatic test_seq();
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_0206, 1'b0);
        acc(32'h0000_0300, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(trg, 1'b0);
        core.fetch(32'h0000_1230);
        acc(32'h0000_0300, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(trg, 1'b1);
        chk(arm, 1'b1);
        core.fetch(32'h0000_1230);
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_0206, 1'b1);
        acc(32'h0000_0300, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(trg, 1'b0);
        wr(DBTU_SEL_TRIG_DEF, 32'h0000_0286, 1'b0);
        acc(32'h0000_0300, DBTU_SIZE_LONG, 32'h0000_0000);
        pcm(32'h0000_1230, 1'b1);
        chk(trg, 1'b1);
        wr(DBTU_SEL_TRACE_CTRL, 32'h0000_0009, 1'b0);
        pcm(32'h0000_1230, 1'b1);
        chk(tst, 1'b1);
        acc(32'h0000_0300, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(tsp, 1'b1);
        iw = '{1'b1, DBTU_SEL_ADDR_LOW, 32'h0000_0500};
        wr(DBTU_SEL_ADDR_LOW, 32'h0000_0600, 1'b1);
        acc(32'h0000_0600, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(am, 1'b1);
        $display("test seq done");
    endtask
    task automatic test_reset();
        @(posedge clk);
        #1;
        chk(arm, 1'b1);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk(arm, 1'b0);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        acc(32'h0000_0600, DBTU_SIZE_LONG, 32'h0000_0000);
        chk(am, 1'b0);
        $display("test reset done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        test_pc();
        test_addr();
        test_data();
        test_seq();
        test_reset();
        tally_and_finish();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
endmodule
